// [inc/ars_pkg.sv]
// constants, states and decode helpers of the auto reclose sequencer
package ars_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // --------------------------------------------------------------
  // shots and pole patterns
  // --------------------------------------------------------------
  localparam int MAX_SHOTS = 8;
  localparam int SHOT_W = 4;
  localparam logic [2:0] POLES_NONE = 3'h0;
  localparam logic [2:0] POLES_ALL = 3'h7;
  localparam logic [3:0] SHOT_RST = 4'h0;

  // --------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_TRIP    = 5'h02,
    ST_DEAD    = 5'h04,
    ST_RECLAIM = 5'h08,
    ST_BLOCKED = 5'h10
  } ars_state_type;

  // --------------------------------------------------------------
  // pole decode
  // --------------------------------------------------------------
  function automatic logic [1:0] ars_pole_count(input logic [2:0] p);
    ars_pole_count = 2'(p[0]) + 2'(p[1]) + 2'(p[2]);
  endfunction

  function automatic logic [2:0] ars_first_pole(input logic [2:0] p);
    ars_first_pole = p & (~p + 3'h1);
  endfunction

endpackage

// [verilog/ars_timer.sv]
// loadable millisecond down-counter with expiry pulse
`timescale 1ns/1ps
`default_nettype none
module ars_timer
  import ars_pkg::*;
#(
  parameter int W = TIMER_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic i_stop,
  input wire logic [W-1:0] i_value,
  output logic o_running,
  output logic o_expired
);

  logic [W-1:0] cnt_q;
  logic run_q;
  logic exp_q;
  wire at_zero = (cnt_q == '0);

  // --------------------------------------------------------------
  // count down on each tick, load wins over stop
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else if (i_load)
    begin
      cnt_q <= i_value;
      run_q <= 1'b1;
      exp_q <= 1'b0;
    end
    else
    begin
      exp_q <= run_q && at_zero && !i_stop;
      if (i_stop || (run_q && at_zero))
        run_q <= 1'b0;
      else if (run_q && i_tick)
        cnt_q <= cnt_q - W'(1);
    end
  end

  assign o_running = run_q;
  assign o_expired = exp_q;

endmodule
`default_nettype wire

// [verilog/ars_seq.sv]
// auto reclose sequencer: trip shaping, dead time, close, reclaim
`timescale 1ns/1ps
`default_nettype none
module ars_seq
  import ars_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int SHOTS = MAX_SHOTS
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_mode_combined,
  input wire logic i_two_phase_single_pole_select,
  input wire logic i_forced_3p_en,
  input wire logic i_allow_3p,
  input wire logic [SHOT_W-1:0] i_max_shots,
  input wire logic [TIMER_W-1:0] i_dead_1p_ms,
  input wire logic [TIMER_W-1:0] i_dead_3p_ms,
  input wire logic [TIMER_W-1:0] i_reclaim_ms,
  input wire logic i_prot_trip,
  input wire logic [2:0] i_fault_phases,
  input wire logic i_fault_earth,
  input wire logic i_phase_known,
  input wire logic [2:0] i_pole_open,
  input wire logic i_block,
  input wire logic i_dyn_block_clear,
  output logic [2:0] o_trip_pole,
  output logic o_close,
  output logic o_stage_ar_ready,
  output logic o_blocked,
  output logic o_dead_running,
  output logic o_reclaim_running,
  output logic [SHOT_W-1:0] o_shot_count
);

  localparam int DIV_W = $clog2(TICK_DIV + 1);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  ars_state_type st_q, st_d;
  logic [2:0] trip_q, trip_d;
  logic [2:0] sel_q, sel_d;
  logic is3p_q, is3p_d;
  logic force_q, force_d;
  logic close_q, close_d;
  logic stage_q, stage_d;
  logic [SHOT_W-1:0] shot_q, shot_d;
  logic [DIV_W-1:0] div_q;
  logic tick_q;

  logic dt_load, dt_stop, dt_run, dt_exp;
  logic [TIMER_W-1:0] dt_val;
  logic rc_load, rc_stop, rc_run, rc_exp;

  // --------------------------------------------------------------
  // millisecond tick
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == DIV_W'(TICK_DIV - 1));
      if (div_q == DIV_W'(TICK_DIV - 1))
        div_q <= '0;
      else
        div_q <= div_q + DIV_W'(1);
    end
  end

  // --------------------------------------------------------------
  // fault classification
  // --------------------------------------------------------------
  wire [1:0] fault_n = ars_pole_count(i_fault_phases);
  wire two_ph_sp = (fault_n == 2'h2) && !i_fault_earth &&
                   i_two_phase_single_pole_select;
  wire sp_fault = i_phase_known && ((fault_n == 2'h1) || two_ph_sp);
  wire ar_ready = (st_q == ST_IDLE) && !i_block;
  // single-only mode starts on single-pole faults, combined on any trip
  wire start_ok = ar_ready && (i_mode_combined || sp_fault);
  wire [2:0] trip_pat = (ar_ready && sp_fault) ?
                        ars_first_pole(i_fault_phases) : POLES_ALL;
  // compare against the poles tripped at start, kept after the trip drops
  wire further_open = !is3p_q && ((i_pole_open & ~sel_q) != POLES_NONE);
  wire tripped_open = ((i_pole_open & trip_q) == trip_q);
  wire [SHOT_W-1:0] max_eff =
    (i_max_shots == '0) ? SHOT_W'(1) :
    (i_max_shots > SHOT_W'(SHOTS)) ? SHOT_W'(SHOTS) : i_max_shots;
  wire shots_left = (shot_q < max_eff);
  wire [2:0] trip_hold = i_prot_trip ? trip_q : POLES_NONE;

  // --------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    trip_d = trip_hold;
    sel_d = sel_q;
    is3p_d = is3p_q;
    force_d = force_q;
    close_d = 1'b0;
    shot_d = shot_q;
    dt_load = 1'b0;
    dt_stop = 1'b0;
    dt_val = is3p_q ? i_dead_3p_ms : i_dead_1p_ms;
    rc_load = 1'b0;
    rc_stop = 1'b0;
    unique case (st_q)
      ST_IDLE:
      begin
        if (i_prot_trip && start_ok)
        begin
          trip_d = trip_pat;
          sel_d = trip_pat;
          is3p_d = (trip_pat == POLES_ALL);
          st_d = ST_TRIP;
        end
        else if (i_prot_trip)
        begin
          trip_d = POLES_ALL;
          st_d = ST_BLOCKED;
        end
      end
      ST_TRIP:
      begin
        if (!i_prot_trip || tripped_open)
        begin
          dt_load = 1'b1;
          st_d = ST_DEAD;
        end
      end
      ST_DEAD:
      begin
        if (i_block)
        begin
          dt_stop = 1'b1;
          st_d = ST_BLOCKED;
          if (!is3p_q && i_forced_3p_en)
          begin
            trip_d = POLES_ALL;
            force_d = 1'b1;
          end
        end
        else if (further_open && i_allow_3p)
        begin
          is3p_d = 1'b1;
          dt_load = 1'b1;
          dt_val = i_dead_3p_ms;
        end
        else if (further_open)
        begin
          dt_stop = 1'b1;
          trip_d = POLES_ALL;
          force_d = 1'b1;
          st_d = ST_BLOCKED;
        end
        else if (dt_exp)
        begin
          close_d = 1'b1;
          rc_load = 1'b1;
          shot_d = shot_q + SHOT_W'(1);
          st_d = ST_RECLAIM;
        end
      end
      ST_RECLAIM:
      begin
        if (i_prot_trip)
        begin
          rc_stop = 1'b1;
          trip_d = POLES_ALL;
          is3p_d = 1'b1;
          if (i_mode_combined && shots_left && !i_block)
            st_d = ST_TRIP;
          else
            st_d = ST_BLOCKED;
        end
        else if (rc_exp)
        begin
          st_d = ST_IDLE;
          shot_d = SHOT_RST;
          is3p_d = 1'b0;
          force_d = 1'b0;
        end
      end
      ST_BLOCKED:
      begin
        trip_d = (i_prot_trip || force_q) ? POLES_ALL : POLES_NONE;
        force_d = force_q && (i_pole_open != POLES_ALL);
        if (i_dyn_block_clear && !i_prot_trip)
        begin
          st_d = ST_IDLE;
          trip_d = POLES_NONE;
          shot_d = SHOT_RST;
          is3p_d = 1'b0;
          force_d = 1'b0;
        end
      end
    endcase
    // protection uses the AR stage only while the sequencer is ready
    stage_d = ar_ready && (i_mode_combined || sp_fault);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_q <= ST_IDLE;
      trip_q <= POLES_NONE;
      sel_q <= POLES_NONE;
      is3p_q <= 1'b0;
      force_q <= 1'b0;
      close_q <= 1'b0;
      stage_q <= 1'b0;
      shot_q <= SHOT_RST;
    end
    else
    begin
      st_q <= st_d;
      trip_q <= trip_d;
      sel_q <= sel_d;
      is3p_q <= is3p_d;
      force_q <= force_d;
      close_q <= close_d;
      stage_q <= stage_d;
      shot_q <= shot_d;
    end
  end

  // --------------------------------------------------------------
  // dead-time and reclaim timers
  // --------------------------------------------------------------
  ars_timer #(.W(TIMER_W)) u_dead (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(tick_q),
    .i_load(dt_load),
    .i_stop(dt_stop),
    .i_value(dt_val),
    .o_running(dt_run),
    .o_expired(dt_exp)
  );

  ars_timer #(.W(TIMER_W)) u_reclaim (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(tick_q),
    .i_load(rc_load),
    .i_stop(rc_stop),
    .i_value(i_reclaim_ms),
    .o_running(rc_run),
    .o_expired(rc_exp)
  );

  assign o_trip_pole = trip_q;
  assign o_close = close_q;
  assign o_stage_ar_ready = stage_q;
  assign o_blocked = (st_q == ST_BLOCKED);
  assign o_dead_running = dt_run;
  assign o_reclaim_running = rc_run;
  assign o_shot_count = shot_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_dead_expiry;
    (st_q == ST_DEAD) && dt_exp && !i_block && !further_open;
  endsequence

  sequence s_close_step;
    close_q && (st_q == ST_RECLAIM) && rc_run;
  endsequence

  a_dead_start: assert property (
    (st_q == ST_TRIP) && !i_prot_trip |=> (st_q == ST_DEAD) && dt_run)
    else $error("dead time not started after trip reset");

  a_close_on_expiry: assert property (
    s_dead_expiry |=> s_close_step ##1 !close_q)
    else $error("close not issued on dead time expiry");

  a_reclaim_with_close: assert property (
    $rose(close_q) |-> rc_run && !$past(rc_run))
    else $error("reclaim timer not started with close");

  a_forced_three_pole: assert property (
    (st_q == ST_DEAD) && i_block && !is3p_q && i_forced_3p_en
    |=> (trip_q == POLES_ALL) && (st_q == ST_BLOCKED))
    else $error("forced three-pole trip missing");

  a_reclaim_success: assert property (
    (st_q == ST_RECLAIM) && rc_exp && !i_prot_trip
    |=> (st_q == ST_IDLE) && (shot_q == SHOT_RST))
    else $error("successful reclose did not return to idle");

  a_final_single_only: assert property (
    (st_q == ST_RECLAIM) && i_prot_trip && !i_mode_combined
    |=> (st_q == ST_BLOCKED) && !stage_q)
    else $error("single-only persistent fault not final");

  a_reclaim_trip_3p: assert property (
    (st_q == ST_RECLAIM) && i_prot_trip |=> (trip_q == POLES_ALL))
    else $error("trip in reclaim time not three-pole");

  a_blocked_no_close: assert property (
    (st_q == ST_BLOCKED) && !i_dyn_block_clear
    |=> !close_q && !dt_run && (st_q == ST_BLOCKED))
    else $error("reclose cycle started while blocked");

  a_shot_limit: assert property (
    $rose(close_q) |-> (shot_q <= max_eff) && (shot_q <= SHOT_W'(SHOTS)))
    else $error("shot count above limit");

  a_single_only_start: assert property (
    (st_q == ST_IDLE) && i_prot_trip && !i_mode_combined && !sp_fault
    |=> (st_q == ST_BLOCKED) && (trip_q == POLES_ALL))
    else $error("three-pole trip started a cycle in single-only mode");

  a_pole_class: assert property (
    (st_q == ST_IDLE) && i_prot_trip && !i_phase_known
    |=> (trip_q == POLES_ALL))
    else $error("single-pole trip without identified phase");

  a_pole_switch: assert property (
    (st_q == ST_DEAD) && !i_block && further_open && i_allow_3p
    |=> is3p_q && dt_run && (st_q == ST_DEAD))
    else $error("no switch to three-pole dead time");

endmodule
`default_nettype wire

// [tb/ars_line_model.sv]
// breaker aux contacts and protection trip model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module ars_line_model
  import ars_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_fault_on,
  input wire logic i_slow,
  input wire logic i_man_close,
  input wire logic [2:0] i_trip_pole,
  input wire logic i_close,
  input wire logic [2:0] i_ext_open,
  output logic o_prot_trip,
  output logic [2:0] o_pole_open
);
  logic [2:0] trip_d1_q, trip_d2_q, pole_q;
  logic [1:0] close_q;
  wire logic [2:0] open_req = i_slow ? trip_d2_q : trip_d1_q;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      trip_d1_q <= POLES_NONE;
      trip_d2_q <= POLES_NONE;
      close_q <= 2'h0;
      pole_q <= POLES_NONE;
    end
    else
    begin
      trip_d1_q <= i_trip_pole;
      trip_d2_q <= trip_d1_q;
      close_q <= {close_q[0], i_close | i_man_close};
      pole_q <= close_q[1] ? POLES_NONE : (pole_q | open_req | i_ext_open);
    end
  end
  assign o_pole_open = pole_q;
  // fault current flows only while every pole is closed
  assign o_prot_trip = i_fault_on & (pole_q == POLES_NONE);
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the auto reclose sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ars_pkg::*;
  localparam int TDIV = 4;
  logic clk, rst, mode, sel, forced, allow, earth, known, blk, clr;
  logic fault_on, slow, man_cl, prot_trip, close, stage, blocked;
  logic dead_run, recl_run;
  logic [2:0] phases, pole_open, trip_pole, ext_open;
  logic [3:0] max_shots, shot;
  logic [15:0] dead1, dead3, reclaim;
  int n_fail = 0;
  int checked = 0;
  int n19;

  ars_seq #(.TICK_DIV(TDIV), .SHOTS(MAX_SHOTS)) dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_mode_combined(mode),
    .i_two_phase_single_pole_select(sel), .i_forced_3p_en(forced),
    .i_allow_3p(allow), .i_max_shots(max_shots), .i_dead_1p_ms(dead1),
    .i_dead_3p_ms(dead3), .i_reclaim_ms(reclaim), .i_prot_trip(prot_trip),
    .i_fault_phases(phases), .i_fault_earth(earth), .i_phase_known(known),
    .i_pole_open(pole_open), .i_block(blk), .i_dyn_block_clear(clr),
    .o_trip_pole(trip_pole), .o_close(close), .o_stage_ar_ready(stage),
    .o_blocked(blocked), .o_dead_running(dead_run),
    .o_reclaim_running(recl_run), .o_shot_count(shot));

  ars_line_model line_u (
    .i_ref_clk(clk), .i_rst(rst), .i_fault_on(fault_on), .i_slow(slow),
    .i_man_close(man_cl), .i_trip_pole(trip_pole), .i_close(close),
    .i_ext_open(ext_open), .o_prot_trip(prot_trip),
    .o_pole_open(pole_open));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic cond(input int s);
    case (s)
      0: cond = trip_pole !== 3'h0;
      1: cond = close === 1'b1;
      2: cond = recl_run === 1'b0;
      3: cond = blocked === 1'b1;
      4: cond = dead_run === 1'b1;
      default: cond = trip_pole === 3'h7;
    endcase
  endfunction

  // bounded wait at falling edges, a timeout counts as a mismatch
  task automatic wait_on(input int s, input int lim);
    int n;
    n = 0;
    while (!cond(s) && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (!cond(s))
      chk(4'h0, 4'h1);
  endtask

  // falling edges until the close pulse, bounded
  task automatic count_close(output int n);
    n = 0;
    while (close !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // close from one tick before to one tick and four cycles after the set dead time
  function automatic logic [3:0] in_win(input int n, input int d);
    in_win = {3'h0, n >= (d - 1) * TDIV && n <= (d + 1) * TDIV + 4};
  endfunction

  // breaker closed by hand, then the dynamic block is left
  task automatic unblock;
    fault_on = 1'b0;
    man_cl = 1'b1;
    @(negedge clk);
    man_cl = 1'b0;
    repeat (4) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk({3'h0, blocked}, 4'h0);
  endtask

  task automatic run_case(input logic m, s, input logic [2:0] ph,
                          input logic k, e, input logic [2:0] exp);
    int n;
    int d;
    mode = m;
    sel = s;
    phases = ph;
    known = k;
    earth = e;
    @(negedge clk);
    chk({3'h0, stage}, {3'h0, m | (exp != 3'h7)});
    fault_on = 1'b1;
    wait_on(0, 20);
    chk({1'b0, trip_pole}, {1'b0, exp});
    fault_on = 1'b0;
    if (!m && exp == 3'h7)
    begin
      wait_on(3, 50);
      unblock();
      return;
    end
    wait_on(4, 50);
    count_close(n);
    d = (exp == 3'h7) ? int'(dead3) : int'(dead1);
    chk(in_win(n, d), 4'h1);
    chk({2'h0, close, recl_run}, 4'h3);
    chk(shot, 4'h1);
    @(negedge clk);
    chk({3'h0, close}, 4'h0);
    wait_on(2, 200);
    @(negedge clk);
    chk({shot[2:0], trip_pole[0]}, 4'h0);
  endtask

  task automatic persist(input logic m, input logic [3:0] lim,
                         input logic [3:0] exp);
    int n;
    int k;
    mode = m;
    max_shots = lim;
    phases = 3'h1;
    known = 1'b1;
    earth = 1'b1;
    fault_on = 1'b1;
    n = 0;
    k = 0;
    while (blocked !== 1'b1 && k < 2000)
    begin
      @(negedge clk);
      k++;
      if (close === 1'b1)
        n++;
    end
    chk(4'(n), exp);
    chk({1'b0, trip_pole}, 4'h7);
    repeat (20) @(negedge clk);
    chk({2'h0, dead_run, blocked}, 4'h1);
    unblock();
  endtask

  initial
  begin
    rst = 1'b1;
    {mode, sel, forced, allow, earth, known, blk, clr} = 8'h00;
    {fault_on, slow, man_cl} = 3'h0;
    phases = 3'h0;
    ext_open = 3'h0;
    max_shots = 4'h8;
    dead1 = 16'h0002;
    dead3 = 16'h0006;
    reclaim = 16'h0003;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    run_case(1'b0, 1'b0, 3'h1, 1'b1, 1'b1, 3'h1);
    run_case(1'b0, 1'b0, 3'h3, 1'b1, 1'b0, 3'h7);
    allow = 1'b1;
    run_case(1'b1, 1'b0, 3'h4, 1'b1, 1'b1, 3'h4);
    run_case(1'b1, 1'b0, 3'h3, 1'b1, 1'b1, 3'h7);
    run_case(1'b1, 1'b1, 3'h3, 1'b1, 1'b0, 3'h1);
    run_case(1'b1, 1'b1, 3'h1, 1'b0, 1'b1, 3'h7);
    // further poles open in the single-pole dead time: three-pole cycle
    known = 1'b1;
    phases = 3'h1;
    fault_on = 1'b1;
    wait_on(0, 20);
    fault_on = 1'b0;
    wait_on(4, 50);
    ext_open = 3'h6;
    @(negedge clk);
    ext_open = 3'h0;
    count_close(n19);
    chk(in_win(n19, int'(dead3)), 4'h1);
    chk({2'h0, blocked, close}, 4'h1);
    wait_on(2, 200);
    @(negedge clk);
    chk(shot, 4'h0);
    slow = 1'b1;
    persist(1'b1, 4'h2, 4'h2);
    persist(1'b0, 4'h8, 4'h1);
    // block during single-pole dead time with forced coupling on
    forced = 1'b1;
    phases = 3'h2;
    fault_on = 1'b1;
    wait_on(0, 20);
    fault_on = 1'b0;
    wait_on(4, 50);
    blk = 1'b1;
    @(negedge clk);
    wait_on(5, 3);
    chk({1'b0, trip_pole}, 4'h7);
    blk = 1'b0;
    wait_on(3, 20);
    unblock();
    tally_and_finish();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
